// ### hw/adc_comparate_and_timing.v
// sequencer of a 10-bit successive-approximation converter
// What this block does
// - comparator operation allowed only in single mode
// - code write starts one comparison on selected channel
// - done flag cleared when comparison starts
// - flag 0 if reference below input, else 1
// - one compare per start, then stop
// - outcome stored in the channel's result bit
// - approximation code drives reference DAC
// - four-clock start delay for every trigger
// - conversion execution counts without fast hold
// - conversion execution counts with fast hold
// - comparison execution counts per speed
// - one-clock end delay before result readable
// - four-clock gap between scanned channels
// - total equals start, executions, gaps, end
// - total runs from trigger to completion pulse
// - sampling lies inside execution phase
// - input above reference saturates at full scale
// - approximation cleared, bits tried msb first
// - continuous scan loops until stop bit written
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_comparate_and_timing #(
    parameter CH_BITS = 4
) (
    input  wire               clock,
    input  wire               reset,
    input  wire [1:0]         scanMode,
    input  wire               comparatorMode,
    input  wire               fastMode,
    input  wire               doubleSpeed,
    input  wire               fastSampleHold,
    input  wire [CH_BITS-1:0] channelSelect,
    input  wire [CH_BITS-1:0] scanLast,
    input  wire               swTrigger,
    input  wire               hwTrigger,
    input  wire               codeWrite,
    input  wire [9:0]         codeWriteData,
    input  wire               scanStopBit,
    input  wire               comparatorHigh,
    input  wire [CH_BITS-1:0] resultReadAddr,
    output reg  [9:0]         dacCode,
    output reg  [CH_BITS-1:0] analogSelect,
    output reg                sampleHold,
    output reg                busy,
    output reg                singleDone,
    output reg                scanDone,
    output reg                completeIrq,
    output reg  [(1<<CH_BITS)-1:0] compare_result_flags,
    output wire [9:0]         resultReadData
);
    localparam NCH = 1 << CH_BITS;
    localparam S_IDLE  = 6'b000001;
    localparam S_START = 6'b000010;
    localparam S_EXEC  = 6'b000100;
    localparam S_GAP   = 6'b001000;
    localparam S_END   = 6'b010000;
    localparam S_FIN   = 6'b100000;

    // execution phase length for the selected mode and speed
    function [8:0] execCount;
        input cmp;
        input fsh;
        input fst;
        input dbl;
        begin
            if (cmp)
                execCount = fst ? (dbl ? `EXEC_CMP_FAST_DBL
                                       : `EXEC_CMP_FAST_NORM)
                                : (dbl ? `EXEC_CMP_SLOW_DBL
                                       : `EXEC_CMP_SLOW_NORM);
            else if (fsh)
                execCount = fst ? (dbl ? `EXEC_FSH_FAST_DBL
                                       : `EXEC_FSH_FAST_NORM)
                                : (dbl ? `EXEC_FSH_SLOW_DBL
                                       : `EXEC_FSH_SLOW_NORM);
            else
                execCount = fst ? (dbl ? `EXEC_FAST_DBL
                                       : `EXEC_FAST_NORM)
                                : (dbl ? `EXEC_SLOW_DBL
                                       : `EXEC_SLOW_NORM);
        end
    endfunction

    reg  [5:0]         state_q;
    reg                cmpRun_q;
    reg  [1:0]         mode_q;
    reg  [CH_BITS-1:0] chan_q;
    reg  [9:0]         sar_q;
    reg  [3:0]         bitPos_q;
    reg  [8:0]         execLen_q;
    reg  [8:0]         slotCnt_q;
    reg                stopReq_q;
    reg                cmpSync1_q;
    reg                cmpSync2_q;
    reg                timerLoad;
    reg  [8:0]         timerCount;
    reg                memWe;
    wire               phaseDone;
    wire [8:0]         slotLen;

    // comparator output is analog, so resynchronise it
    always @(posedge clock) begin
        if (reset) begin
            cmpSync1_q <= 1'b0;
            cmpSync2_q <= 1'b0;
        end else begin
            cmpSync1_q <= comparatorHigh;
            cmpSync2_q <= cmpSync1_q;
        end
    end

    // ten equal slots per conversion; slot end samples the comparator
    assign slotLen = execLen_q / 9'd10;

    adc_phase_timer #(.WIDTH(9)) timer (
        .clock (clock),
        .reset (reset),
        .load  (timerLoad),
        .count (timerCount),
        .done  (phaseDone)
    );

    adc_result_mem #(.CH_BITS(CH_BITS), .WIDTH(10)) results (
        .clock     (clock),
        .writeEn   (memWe),
        .writeAddr (chan_q),
        .writeData (sar_q),
        .readAddr  (resultReadAddr),
        .readData  (resultReadData)
    );

    // one shared timer: each phase loads its own terminal count
    // a refused trigger still loads it; idle never reads its done
    always @* begin
        timerLoad  = 1'b0;
        timerCount = `START_DELAY_CYC;
        memWe      = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (swTrigger || hwTrigger || codeWrite) begin
                    timerLoad  = 1'b1;
                    timerCount = `START_DELAY_CYC;
                end
            end
            S_START, S_GAP: begin
                if (phaseDone) begin
                    timerLoad  = 1'b1;
                    timerCount = execLen_q;
                end
            end
            S_EXEC: begin
                if (phaseDone) begin
                    timerLoad = 1'b1;
                    memWe     = !cmpRun_q;
                    if (!cmpRun_q && mode_q != `MODE_SINGLE
                        && !(chan_q == scanLast
                             && mode_q == `MODE_SHOT_SCAN)
                        && !stopReq_q && !scanStopBit)
                        timerCount = `GAP_DELAY_CYC;
                    else
                        timerCount = `END_DELAY_CYC;
                end
            end
            default: begin
                timerLoad = 1'b0;
            end
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            state_q              <= S_IDLE;
            cmpRun_q             <= 1'b0;
            mode_q               <= `MODE_SINGLE;
            chan_q               <= {CH_BITS{1'b0}};
            sar_q                <= `CODE_ZERO;
            bitPos_q             <= 4'h0;
            execLen_q            <= `EXEC_SLOW_NORM;
            slotCnt_q            <= 9'd0;
            stopReq_q            <= 1'b0;
            dacCode              <= `CODE_ZERO;
            analogSelect         <= {CH_BITS{1'b0}};
            sampleHold           <= 1'b0;
            busy                 <= 1'b0;
            singleDone           <= 1'b0;
            scanDone             <= 1'b0;
            completeIrq          <= 1'b0;
            compare_result_flags <= {NCH{1'b0}};
        end else begin
            completeIrq <= 1'b0;
            // latch the stop so a one-cycle pulse in a gap is not lost
            if (scanStopBit && busy && mode_q != `MODE_SINGLE)
                stopReq_q <= 1'b1;
            case (state_q)
                S_IDLE: begin
                    stopReq_q <= 1'b0;
                    if (codeWrite && comparatorMode
                        && scanMode == `MODE_SINGLE) begin
                        cmpRun_q   <= 1'b1;
                        mode_q     <= `MODE_SINGLE;
                        chan_q     <= channelSelect;
                        sar_q      <= codeWriteData;
                        singleDone <= 1'b0;
                        busy       <= 1'b1;
                        execLen_q  <= execCount(1'b1, fastSampleHold,
                                                fastMode, doubleSpeed);
                        state_q    <= S_START;
                    end else if ((swTrigger || hwTrigger)
                                 && !comparatorMode) begin
                        cmpRun_q  <= 1'b0;
                        mode_q    <= scanMode;
                        chan_q    <= (scanMode == `MODE_SINGLE)
                                     ? channelSelect : {CH_BITS{1'b0}};
                        busy      <= 1'b1;
                        if (scanMode == `MODE_SINGLE)
                            singleDone <= 1'b0;
                        else
                            scanDone <= 1'b0;
                        execLen_q <= execCount(1'b0, fastSampleHold,
                                               fastMode, doubleSpeed);
                        state_q   <= S_START;
                    end
                end
                S_START, S_GAP: begin
                    if (phaseDone) begin
                        analogSelect <= chan_q;
                        if (cmpRun_q) begin
                            dacCode <= sar_q;
                        end else begin
                            sar_q    <= 10'h200;
                            dacCode  <= 10'h200;
                            bitPos_q <= `CODE_MSB_POS;
                        end
                        sampleHold <= 1'b1;
                        slotCnt_q  <= 9'd0;
                        state_q    <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    slotCnt_q <= slotCnt_q + 9'd1;
                    // slots under three cycles would outrun the synchroniser
                    if (slotCnt_q == 9'd3)
                        sampleHold <= 1'b0;
                    if (!cmpRun_q && slotCnt_q == slotLen - 9'd1
                        && bitPos_q != 4'hf) begin
                        slotCnt_q <= 9'd0;
                        // above reference keeps bit; top input gives 3ff
                        if (cmpSync2_q) begin
                            if (bitPos_q != 4'h0) begin
                                sar_q[bitPos_q - 4'h1] <= 1'b1;
                                dacCode <= sar_q
                                    | (10'h001 << (bitPos_q - 4'h1));
                            end
                        end else begin
                            sar_q[bitPos_q] <= 1'b0;
                            if (bitPos_q != 4'h0) begin
                                sar_q[bitPos_q - 4'h1] <= 1'b1;
                                dacCode <= (sar_q
                                    & ~(10'h001 << bitPos_q))
                                    | (10'h001 << (bitPos_q - 4'h1));
                            end
                        end
                        bitPos_q <= bitPos_q - 4'h1;
                    end
                    if (phaseDone) begin
                        sampleHold <= 1'b0;
                        // outcome from the synchronised comparator at phase end
                        if (cmpRun_q)
                            compare_result_flags[chan_q]
                                <= !cmpSync2_q;
                        if (timerCount == `GAP_DELAY_CYC) begin
                            chan_q  <= chan_q + {{(CH_BITS-1){1'b0}}, 1'b1};
                            if (chan_q == scanLast)
                                chan_q <= {CH_BITS{1'b0}};
                            state_q <= S_GAP;
                        end else begin
                            state_q <= S_END;
                        end
                    end
                end
                // done flag and pulse rise together, so no gap is visible
                S_END: begin
                    if (phaseDone) begin
                        busy        <= 1'b0;
                        completeIrq <= 1'b1;
                        if (mode_q == `MODE_SINGLE)
                            singleDone <= 1'b1;
                        else
                            scanDone <= 1'b1;
                        cmpRun_q <= 1'b0;
                        state_q  <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ### hw/adc_phase_timer.v
// single down counter that times every sequencer phase
`timescale 1ns/1ps
module adc_phase_timer #(
    parameter WIDTH = 9
) (
    input  wire             clock,
    input  wire             reset,
    input  wire             load,
    input  wire [WIDTH-1:0] count,
    output reg              done
);
    reg [WIDTH-1:0] remain_q;

    // done pulses in the last cycle of a phase loaded with count cycles
    always @(posedge clock) begin
        if (reset) begin
            remain_q <= {WIDTH{1'b0}};
            done     <= 1'b0;
        end else if (load) begin
            remain_q <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            done     <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
        end else if (remain_q != {WIDTH{1'b0}}) begin
            remain_q <= remain_q - {{(WIDTH-1){1'b0}}, 1'b1};
            done     <= (remain_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done <= 1'b0;
        end
    end
endmodule

// ### hw/adc_result_mem.v
// per-channel 10-bit result store with registered read port
`timescale 1ns/1ps
module adc_result_mem #(
    parameter CH_BITS = 4,
    parameter WIDTH   = 10
) (
    input  wire               clock,
    input  wire               writeEn,
    input  wire [CH_BITS-1:0] writeAddr,
    input  wire [WIDTH-1:0]   writeData,
    input  wire [CH_BITS-1:0] readAddr,
    output reg  [WIDTH-1:0]   readData
);
    reg [WIDTH-1:0] store [0:(1<<CH_BITS)-1];

    always @(posedge clock) begin
        if (writeEn) begin
            store[writeAddr] <= writeData;
        end
        readData <= store[readAddr];
    end
endmodule

// ### hw/adc_seq_consts.vh
// timing counts, field widths and reset values of the converter sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
`define START_DELAY_CYC      9'd4
`define END_DELAY_CYC        9'd1
`define GAP_DELAY_CYC        9'd4
`define EXEC_SLOW_NORM       9'd294
`define EXEC_SLOW_DBL        9'd168
`define EXEC_FAST_NORM       9'd126
`define EXEC_FAST_DBL        9'd84
`define EXEC_FSH_SLOW_NORM   9'd186
`define EXEC_FSH_SLOW_DBL    9'd96
`define EXEC_FSH_FAST_NORM   9'd90
`define EXEC_FSH_FAST_DBL    9'd48
`define EXEC_CMP_SLOW_NORM   9'd42
`define EXEC_CMP_SLOW_DBL    9'd24
`define EXEC_CMP_FAST_NORM   9'd18
`define EXEC_CMP_FAST_DBL    9'd12
`define CODE_FULL_SCALE      10'h3ff
`define CODE_ZERO            10'h000
`define CODE_MSB_POS         4'd9
`define MODE_SINGLE          2'h0
`define MODE_SHOT_SCAN       2'h1
`define MODE_CONT_SCAN       2'h2
`endif

// ### testbench/adc_comparate_and_timing_bench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_comparate_and_timing_bench;
    reg          clock = 1'b0;
    reg          reset = 1'b1;
    reg  [1:0]   scanMode = 2'h0;
    reg          comparatorMode = 1'b0;
    reg          fastMode = 1'b0;
    reg          doubleSpeed = 1'b0;
    reg          fastSampleHold = 1'b0;
    reg  [3:0]   channelSelect = 4'h0;
    reg  [3:0]   scanLast = 4'h0;
    reg          swTrigger = 1'b0;
    reg          hwTrigger = 1'b0;
    reg          codeWrite = 1'b0;
    reg  [9:0]   codeWriteData = 10'h000;
    reg          scanStopBit = 1'b0;
    reg  [3:0]   resultReadAddr = 4'h0;
    reg  [191:0] levels = 192'h0;
    reg  [15:0]  expFlags = 16'h0000;
    reg  [36:0]  rows [0:5];
    reg  [11:0]  vh;
    reg          fl;
    reg  [7:0]   cyc;
    wire         comparatorHigh;
    wire [9:0]   dacCode;
    wire [9:0]   resultReadData;
    wire [3:0]   analogSelect;
    wire         sampleHold;
    wire         busy;
    wire         singleDone;
    wire         scanDone;
    wire         completeIrq;
    wire [15:0]  compare_result_flags;
    integer      miscompares = 0;
    integer      n_checks = 0;
    integer      n;
    integer      i;

    analog_comparator_model partner (.dacCode(dacCode),
        .analogSelect(analogSelect), .levels(levels),
        .comparatorHigh(comparatorHigh));
    adc_comparate_and_timing DUT (.clock(clock), .reset(reset),
        .scanMode(scanMode), .comparatorMode(comparatorMode),
        .fastMode(fastMode), .doubleSpeed(doubleSpeed),
        .fastSampleHold(fastSampleHold), .channelSelect(channelSelect),
        .scanLast(scanLast), .swTrigger(swTrigger), .hwTrigger(hwTrigger),
        .codeWrite(codeWrite), .codeWriteData(codeWriteData),
        .scanStopBit(scanStopBit), .comparatorHigh(comparatorHigh),
        .resultReadAddr(resultReadAddr), .dacCode(dacCode),
        .analogSelect(analogSelect), .sampleHold(sampleHold), .busy(busy),
        .singleDone(singleDone), .scanDone(scanDone),
        .completeIrq(completeIrq),
        .compare_result_flags(compare_result_flags),
        .resultReadData(resultReadData));

    initial begin
        forever #4 clock = ~clock;
    end

    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // counts cycles from the start pulse to the completion pulse
    task runOp(input integer again);
        begin
            n = 0;
            while (n == 0 || completeIrq !== 1'b1) begin
                @(negedge clock);
                n = n + 1;
                swTrigger = 1'b0;
                hwTrigger = 1'b0;
                codeWrite = (n == again);
                if (n == again)
                    codeWriteData = ~codeWriteData;
                if (n > 2000) begin
                    miscompares = miscompares + 1;
                    stop_test;
                end
            end
        end
    endtask

    task readResult(input [3:0] ch, input [9:0] code);
        begin
            resultReadAddr = ch;
            @(negedge clock);
            check("result", resultReadData, code);
        end
    endtask

    // odd channels start from the hardware trigger, even ones from software
    task conv(input [2:0] m, input [3:0] ch, input [11:0] v,
              input [9:0] code, input [8:0] ex);
        begin
            {fastMode, doubleSpeed, fastSampleHold} = m;
            levels[ch*12 +: 12] = v;
            channelSelect = ch;
            hwTrigger = ch[0];
            swTrigger = !ch[0];
            runOp(0);
            check("conv time", n, ex + 6);
            check("single done", {busy, singleDone}, 2'h1);
            readResult(ch, code);
        end
    endtask

    initial begin
        rows[0] = {2'h0, 4'h3, 10'h100, 12'h258, 1'b0, 8'h30};
        rows[1] = {2'h1, 4'h5, 10'h100, 12'h190, 1'b1, 8'h1e};
        rows[2] = {2'h2, 4'hf, 10'h000, 12'h001, 1'b0, 8'h18};
        rows[3] = {2'h3, 4'h0, 10'h3ff, 12'h7fe, 1'b0, 8'h12};
        rows[4] = {2'h0, 4'hf, 10'h3ff, 12'h7d0, 1'b1, 8'h30};
        rows[5] = {2'h3, 4'h7, 10'h001, 12'h000, 1'b1, 8'h12};
        repeat (10) @(negedge clock);
        reset = 1'b0;
        check("reset", {busy, singleDone, completeIrq, compare_result_flags}, 0);
        comparatorMode = 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            {fastMode, doubleSpeed, channelSelect, codeWriteData, vh, fl, cyc}
                = rows[i];
            levels[channelSelect*12 +: 12] = vh;
            expFlags[channelSelect] = fl;
            codeWrite = 1'b1;
            runOp(0);
            check("cmp time", n, cyc);
            check("flags", compare_result_flags, expFlags);
            check("cmp done", {busy, singleDone}, 2'h1);
            $display("comparator row %0d done", i);
        end
        {fastMode, doubleSpeed, channelSelect, codeWriteData} = 16'h0d00;
        codeWrite = 1'b1;
        runOp(3);
        check("busy write time", n, 48);
        check("busy write flags", compare_result_flags, expFlags);
        scanMode = 2'h1;
        codeWrite = 1'b1;
        @(negedge clock);
        codeWrite = 1'b0;
        repeat (60) @(negedge clock);
        check("refused", {busy, compare_result_flags}, expFlags);
        $display("refusal and busy write done");
        comparatorMode = 1'b0;
        scanMode = 2'h0;
        conv(3'h0, 4'h2, 12'h258, 10'h12c, 294);
        conv(3'h2, 4'h3, 12'h190, 10'h0c8, 168);
        conv(3'h4, 4'h4, 12'h000, 10'h000, 126);
        conv(3'h6, 4'h6, 12'h002, 10'h001, 84);
        conv(3'h1, 4'h9, 12'hfff, 10'h3ff, 186);
        conv(3'h7, 4'h8, 12'h7fe, 10'h3ff, 48);
        $display("single conversions done");
        scanMode = 2'h1;
        scanLast = 4'h1;
        levels[23:0] = {12'h3e8, 12'h100};
        swTrigger = 1'b1;
        runOp(0);
        check("scan time", n, 106);
        check("scan done", scanDone, 1'b1);
        readResult(4'h0, 10'h080);
        readResult(4'h1, 10'h1f4);
        $display("single-shot scan done");
        scanMode = 2'h2;
        scanLast = 4'h0;
        swTrigger = 1'b1;
        repeat (200) @(negedge clock);
        swTrigger = 1'b0;
        check("scan looping", busy, 1'b1);
        scanStopBit = 1'b1;
        for (i = 0; i < 120 && busy === 1'b1; i = i + 1)
            @(negedge clock);
        scanStopBit = 1'b0;
        check("scan stopped", busy, 1'b0);
        $display("continuous scan done");
        comparatorMode = 1'b1;
        scanMode = 2'h0;
        codeWrite = 1'b1;
        @(negedge clock);
        codeWrite = 1'b0;
        repeat (8) @(negedge clock);
        check("mid busy", busy, 1'b1);
        reset = 1'b1;
        repeat (3) @(negedge clock);
        reset = 1'b0;
        check("mid reset", {busy, singleDone, completeIrq, dacCode}, 0);
        check("mid reset flags", compare_result_flags, 0);
        $display("mid-run reset done");
        stop_test;
    end
endmodule

// ### testbench/adc_seq_assertions.sv
// timing and result checks for the converter sequencer
`timescale 1ns/1ps
module adc_seq_checker #(
    parameter CH_BITS = 4
) (
    input wire                    clock,
    input wire                    reset,
    input wire [1:0]              scanMode,
    input wire                    comparatorMode,
    input wire                    fastMode,
    input wire                    doubleSpeed,
    input wire                    swTrigger,
    input wire                    hwTrigger,
    input wire                    codeWrite,
    input wire [9:0]              codeWriteData,
    input wire [9:0]              dacCode,
    input wire [CH_BITS-1:0]      analogSelect,
    input wire                    sampleHold,
    input wire                    busy,
    input wire                    singleDone,
    input wire                    completeIrq,
    input wire [(1<<CH_BITS)-1:0] compare_result_flags
);
    localparam NF = 1 << CH_BITS;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire cmpStart = codeWrite && !busy && comparatorMode && scanMode == 2'h0;
    wire convStart = swTrigger && !busy && !comparatorMode;
    wire [NF-1:0] own = {{(NF-1){1'b0}}, 1'b1} << analogSelect;
    reg  [8:0] elapsed_q;
    reg  [8:0] expect_q;
    // comparator runs only, so conversions never arm the duration check
    always @(posedge clock) begin
        if (reset || cmpStart) begin
            elapsed_q <= reset ? 9'h000 : 9'h001;
            expect_q <= fastMode ? (doubleSpeed ? 9'h012 : 9'h018)
                                 : (doubleSpeed ? 9'h01e : 9'h030);
        end else if (completeIrq) begin
            elapsed_q <= 9'h000;
        end else if (elapsed_q != 9'h000 && elapsed_q != 9'h1ff) begin
            elapsed_q <= elapsed_q + 9'h001;
        end
    end
    chk_start_clears_done: assert property (
        cmpStart |=> busy && !singleDone)
        else $error("comparison start left done set or busy low");
    chk_scan_no_compare: assert property (
        codeWrite && comparatorMode && scanMode != 2'h0 && !busy
        && !swTrigger && !hwTrigger |=> !busy)
        else $error("comparison started outside single mode");
    chk_dac_gets_code: assert property (
        cmpStart |-> ##5 dacCode == $past(codeWriteData, 5))
        else $error("dac code differs from written code");
    chk_cmp_duration: assert property (
        completeIrq && elapsed_q != 9'h000 |-> elapsed_q == expect_q)
        else $error("comparison took the wrong number of cycles");
    chk_irq_one_pulse: assert property (
        completeIrq |=> !completeIrq)
        else $error("completion pulse longer than one cycle");
    chk_done_at_irq: assert property (
        completeIrq && scanMode == 2'h0 |-> singleDone && !busy)
        else $error("done flag not set with completion pulse");
    chk_flag_own_bit: assert property (
        ((compare_result_flags ^ $past(compare_result_flags))
        & ~$past(own)) == {NF{1'b0}})
        else $error("result flag of another channel changed");
    chk_start_delay: assert property (
        convStart |=> !sampleHold[*4] ##1 sampleHold[*4] ##1 !sampleHold)
        else $error("sampling window misplaced after trigger");
    chk_irq_after_busy: assert property (
        completeIrq |-> $past(busy))
        else $error("completion pulse without a running operation");
    cover property (cmpStart);
    cover property (convStart);
    cover property (completeIrq && scanMode == 2'h1);
endmodule
bind adc_comparate_and_timing adc_seq_checker #(.CH_BITS(CH_BITS)) seqChk (
    .clock, .reset, .scanMode, .comparatorMode, .fastMode, .doubleSpeed,
    .swTrigger, .hwTrigger, .codeWrite, .codeWriteData, .dacCode,
    .analogSelect, .sampleHold, .busy, .singleDone, .completeIrq,
    .compare_result_flags);

// ### testbench/analog_comparator_model.sv
// behavioural analog comparator with its reference dac
`timescale 1ns/1ps
module analog_comparator_model (
    input  wire [9:0]   dacCode,
    input  wire [3:0]   analogSelect,
    input  wire [191:0] levels,
    output wire         comparatorHigh
);
    // inputs and dac voltage both kept in half-lsb steps
    wire [11:0] vin = levels[analogSelect*12 +: 12];
    wire [11:0] vref = (dacCode == 10'h000) ? 12'h000 :
                       {1'b0, dacCode, 1'b0} - 12'h001;
    // inputs beyond full scale stay high on every code
    assign comparatorHigh = vin > vref;
endmodule
